// ==== inc/cps_pkg.sv ====
// Constants, codes and carrier types for the cable port status page.
package cps_pkg;

  // ---------------------------------------------------------------------------
  // Widths and limits
  // ---------------------------------------------------------------------------
  localparam int MAX_PORTS = 16;
  localparam int SEL_W = 4;
  localparam int PAGE_W = 3;
  localparam int IDX_W = 4;
  localparam int LINE_W = 2;
  localparam int SPEED_W = 3;
  localparam int DATA_W = 32;
  localparam int CON_CNT_W = 26;

  // ---------------------------------------------------------------------------
  // Register indices; the byte address is four times the index
  // ---------------------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_EVENT = 4'h6;
  localparam logic [IDX_W-1:0] IDX_SELECT = 4'h7;
  localparam logic [IDX_W-1:0] IDX_PORT_A = 4'h8;
  localparam logic [IDX_W-1:0] IDX_PORT_B = 4'h9;
  localparam logic [IDX_W-1:0] IDX_PORT_C = 4'ha;
  localparam logic [PAGE_W-1:0] PAGE_PORT_STATUS = 3'h0;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int POS_PAGE = 0;
  localparam int POS_PORT = 4;
  localparam int POS_PEI = 0;
  localparam int POS_TREE = 1;
  localparam int POS_LINE_A = 6;
  localparam int POS_LINE_B = 4;
  localparam int POS_CHILD = 3;
  localparam int POS_CONN = 2;
  localparam int POS_RECEIVE_GOOD = 1;
  localparam int POS_DIS = 0;
  localparam int POS_SPEED = 5;
  localparam int POS_PIE = 4;
  localparam int POS_FAULT = 3;
  localparam int POS_SBF = 2;
  localparam int POS_DSCR = 1;
  localparam int POS_BONLY = 0;
  localparam int POS_DCA = 7;

  // ---------------------------------------------------------------------------
  // Bus constants
  // ---------------------------------------------------------------------------
  localparam int TRANS_ACT_BIT = 1;
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int DEBOUNCE_MS = 341;
  localparam int DEBOUNCE_CYCLES = (CLK_HZ / 1000) * DEBOUNCE_MS;

  // ---------------------------------------------------------------------------
  // Codes and carriers
  // ---------------------------------------------------------------------------
  typedef enum logic [LINE_W-1:0] {
    LINE_INVALID = 2'h0,
    LINE_ONE = 2'h1,
    LINE_ZERO = 2'h2,
    LINE_Z = 2'h3
  } cps_line_type;

  typedef enum logic [SPEED_W-1:0] {
    SPEED_S100 = 3'h0,
    SPEED_S200 = 3'h1,
    SPEED_S400 = 3'h2,
    SPEED_S800 = 3'h3,
    SPEED_S1600 = 3'h4,
    SPEED_S3200 = 3'h5,
    SPEED_RSVD6 = 3'h6,
    SPEED_RSVD7 = 3'h7
  } cps_speed_type;

  typedef struct packed {
    cps_line_type tpa_state;
    cps_line_type tpb_state;
    logic child_raw;
    logic in_suspend;
    logic beta_mode;
    logic bias_ok;
    logic tones_seen;
    logic speed_negotiated;
    logic signal_valid;
    logic tones_only;
    logic speed_load;
    cps_speed_type agreed_speed;
    logic resume_fault;
    logic suspend_fault;
    logic standby_error;
    logic standby_exit;
    logic standby_remote_clear;
    logic beta_only_cfg;
    logic dc_detect;
    logic port_event;
  } cps_port_in_type;

  typedef struct packed {
    cps_line_type line_a;
    cps_line_type line_b;
    logic child_role;
    logic receive_good;
    logic dis;
    cps_speed_type speed;
    logic port_event_irq_enable;
    logic fault;
    logic standby_fault;
    logic scramble_off;
    logic beta_only;
    logic direct_current_attach;
    logic standby_clear;
  } cps_port_st_type;

  localparam cps_port_st_type PORT_ST_RST = '{
    line_a: LINE_INVALID,
    line_b: LINE_INVALID,
    child_role: 1'b1,
    receive_good: 1'b0,
    dis: 1'b0,
    speed: SPEED_S100,
    port_event_irq_enable: 1'b0,
    fault: 1'b0,
    standby_fault: 1'b0,
    scramble_off: 1'b0,
    beta_only: 1'b0,
    direct_current_attach: 1'b0,
    standby_clear: 1'b0
  };

endpackage

// ==== rtl/cps_debounce.sv ====
// Connection debounce: a high level must hold a full count of cycles before it is reported.
`timescale 1ns/1ns
module cps_debounce #(
  parameter int CYCLES = cps_pkg::DEBOUNCE_CYCLES,
  parameter int CNT_W = cps_pkg::CON_CNT_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic level,
  output logic stable
);
  import cps_pkg::*;

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic next_stable;

  if (CYCLES < 1 || CYCLES >= (2 ** CNT_W)) begin : g_bad
    $error("cps_debounce: CYCLES does not fit the counter");
  end

  // A drop of the level clears the report at once; only the rise is debounced.
  always_comb begin
    next_count = '0;
    next_stable = 1'b0;
    if (level) begin
      next_count = (count == CNT_W'(CYCLES - 1)) ? count : count + 1'b1;
      next_stable = stable || (count == CNT_W'(CYCLES - 1));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= '0;
      stable <= 1'b0;
    end else begin
      count <= next_count;
      stable <= next_stable;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  logic [CNT_W-1:0] run;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run <= '0;
    end else begin
      run <= !level ? '0 : ((run == CNT_W'(CYCLES)) ? run : run + 1'b1);
    end
  end

  property p_con_after_hold;
    @(posedge hclk) disable iff (!hresetn) $rose(stable) |-> (run == CNT_W'(CYCLES));
  endproperty
  a_con_after_hold: assert property (p_con_after_hold) // see R5
    else $error("connection reported before the debounce hold");

  property p_con_drops;
    @(posedge hclk) disable iff (!hresetn) !level |=> !stable;
  endproperty
  a_con_drops: assert property (p_con_drops) // see R5
    else $error("connection still reported after the level fell");
endmodule

// ==== rtl/cps_port_page.sv ====
// Per-port status and control page of a three-port cable physical layer, on AHB-Lite.
//
// Behaviour
// R1: Report selected port's TPA line state: 11 Z, 01 one, 10 zero, 00 invalid.
// R2: Report selected port's TPB line state with the same two-bit code.
// R3: Child bit reads 1 for child, 0 parent; unconnected, disabled, suspended read child.
// R4: Child bit is meaningless from bus reset until tree identification completes.
// R5: Connected sets after about 341 ms stable; hardware reset clears, bus reset keeps.
// R6: Coupled connection counts once tones are seen and speed negotiation finished.
// R7: Receive-good follows debounced bias in legacy mode, valid signal in Beta mode; the code takes bias_ok undebounced in legacy mode.
// R8: Receive-good stays false while only connection tones are seen in Beta mode.
// R9: Disable bit 1 disables the port; hardware reset clears it, bus reset keeps.
// R10: A disabled port still tones but never becomes active.
// R11: Three-bit agreed speed, loaded at connection or from self-identification.
// R12: With event enable set, a port event sets the event flag and notifies link.
// R13: Resume or suspend fault sets the fault bit and suspends the port.
// R14: Writing 1 clears the fault bit; hardware reset clears, bus reset keeps.
// R15: Standby error bit sets on error, clears on standby exit, write 1 or remote.
// R16: Scrambler-disable bit 1 sends packet data unscrambled on that port.
// R17: Beta-only indicator reads the port's Beta-only configuration, else 0.
// R18: Direct-current attach reads 1 when the legacy detect senses a DC connection.
// R19: Page 0 and a port number select the page; absent ports read all zero.
// R20: Speed codes 000 S100 up to 101 S3200; 110 and 111 reserved.
// R21: Writes to read-only status fields of the page are ignored.
`timescale 1ns/1ns
module cps_port_page #(
  parameter int NPORTS = 3,
  parameter int DEBOUNCE_CYCLES = cps_pkg::DEBOUNCE_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic bus_reset,
  input wire logic tree_id_done,
  input wire cps_pkg::cps_port_in_type port_in [NPORTS],
  output logic [NPORTS-1:0] port_disable,
  output logic [NPORTS-1:0] scramble_off,
  output logic [NPORTS-1:0] port_suspend,
  output logic [NPORTS-1:0] standby_err_clear,
  output logic port_event_notify
);
  import cps_pkg::*;

  if (NPORTS < 1 || NPORTS > MAX_PORTS) begin : g_bad_ports
    $error("cps_port_page: NPORTS out of range");
  end

  // ---------------------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------------------
  logic addr_take;
  logic addr_ok;
  logic [IDX_W-1:0] addr_idx;
  logic wr_pend;
  logic next_wr_pend;
  logic [IDX_W-1:0] wr_idx;
  logic [IDX_W-1:0] next_wr_idx;
  logic [31:0] next_hrdata;
  logic wr_en;

  assign addr_take = hsel && hready && htrans[TRANS_ACT_BIT];
  assign addr_idx = haddr[IDX_W+1:2];
  assign addr_ok = (haddr[31:IDX_W+2] == '0) && (hsize == SIZE_WORD);
  assign wr_en = wr_pend;

  always_comb begin
    next_wr_pend = addr_take && hwrite && addr_ok;
    next_wr_idx = addr_take ? addr_idx : wr_idx;
  end

  // The slave never stalls, so the data phase of a write is always one cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx <= '0;
      hrdata <= RDATA_ZERO;
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end else begin
      wr_pend <= next_wr_pend;
      wr_idx <= next_wr_idx;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end
  end

  // ---------------------------------------------------------------------------
  // Page and port selection, global event state
  // ---------------------------------------------------------------------------
  logic [PAGE_W-1:0] page_sel;
  logic [PAGE_W-1:0] next_page_sel;
  logic [SEL_W-1:0] port_sel;
  logic [SEL_W-1:0] next_port_sel;
  logic port_event_irq_flag;
  logic next_pei;
  logic tree_valid;
  logic next_tree_valid;
  logic page_ok;
  logic [NPORTS-1:0] ev;

  // Compared as integers so that a full sixteen-port build does not wrap the bound to zero.
  assign page_ok = (page_sel == PAGE_PORT_STATUS) && (int'(port_sel) < NPORTS);

  always_comb begin
    next_page_sel = page_sel;
    next_port_sel = port_sel;
    next_pei = port_event_irq_flag;
    next_tree_valid = tree_valid;
    if (wr_en && wr_idx == IDX_SELECT) begin // see R19
      next_page_sel = hwdata[POS_PAGE +: PAGE_W];
      next_port_sel = hwdata[POS_PORT +: SEL_W];
    end
    if (wr_en && wr_idx == IDX_EVENT && hwdata[POS_PEI]) begin
      next_pei = 1'b0;
    end
    // A new event in the clearing cycle survives the clear.
    if (|ev) begin // see R12
      next_pei = 1'b1;
    end
    if (tree_id_done) begin // see R4
      next_tree_valid = 1'b1;
    end
    if (bus_reset) begin // see R4
      next_tree_valid = 1'b0;
    end
  end

  // Bus reset touches only the tree flag; selection and enables survive it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      page_sel <= PAGE_PORT_STATUS;
      port_sel <= '0;
      port_event_irq_flag <= 1'b0;
      tree_valid <= 1'b0;
      port_event_notify <= 1'b0;
    end else begin
      page_sel <= next_page_sel;
      port_sel <= next_port_sel;
      port_event_irq_flag <= next_pei;
      tree_valid <= next_tree_valid;
      port_event_notify <= next_pei;
    end
  end

  // ---------------------------------------------------------------------------
  // Per-port state
  // ---------------------------------------------------------------------------
  cps_port_st_type st [NPORTS];
  cps_port_st_type next_st [NPORTS];
  logic [NPORTS-1:0] con;
  logic [NPORTS-1:0] con_cond;

  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    logic wsel;

    // A coupled link counts as connected only once speed training is over.
    assign con_cond[p] = port_in[p].beta_mode ?
        (port_in[p].tones_seen && port_in[p].speed_negotiated) : port_in[p].bias_ok; // see R6
    assign wsel = wr_en && page_ok && (port_sel == SEL_W'(p));
    assign ev[p] = st[p].port_event_irq_enable && port_in[p].port_event; // see R12

    cps_debounce #(
      .CYCLES(DEBOUNCE_CYCLES),
      .CNT_W(CON_CNT_W)
    ) u_debounce (
      .hclk(hclk),
      .hresetn(hresetn),
      .level(con_cond[p]),
      .stable(con[p])
    );

    always_comb begin
      next_st[p] = st[p];
      next_st[p].line_a = port_in[p].tpa_state; // see R1
      next_st[p].line_b = port_in[p].tpb_state; // see R2
      next_st[p].child_role = (!con[p] || st[p].dis || st[p].fault || port_in[p].in_suspend) ?
          1'b1 : port_in[p].child_raw; // see R3
      next_st[p].receive_good = port_in[p].beta_mode ?
          (port_in[p].signal_valid && !port_in[p].tones_only) : port_in[p].bias_ok; // see R7, R8
      if (port_in[p].speed_load) begin
        next_st[p].speed = port_in[p].agreed_speed; // see R11, R20
      end
      next_st[p].beta_only = port_in[p].beta_only_cfg; // see R17
      next_st[p].direct_current_attach = port_in[p].dc_detect; // see R18
      next_st[p].standby_clear = 1'b0;
      // Only the writable bits of the page take write data.
      if (wsel && wr_idx == IDX_PORT_A) begin // see R21
        next_st[p].dis = hwdata[POS_DIS]; // see R9
      end
      if (wsel && wr_idx == IDX_PORT_B) begin // see R21
        next_st[p].port_event_irq_enable = hwdata[POS_PIE];
        next_st[p].scramble_off = hwdata[POS_DSCR]; // see R16
        if (hwdata[POS_FAULT]) begin
          next_st[p].fault = 1'b0; // see R14
        end
        if (hwdata[POS_SBF]) begin
          next_st[p].standby_fault = 1'b0; // see R15
          next_st[p].standby_clear = 1'b1;
        end
      end
      if (port_in[p].standby_remote_clear) begin // see R15
        next_st[p].standby_fault = 1'b0;
        next_st[p].standby_clear = 1'b1;
      end
      if (port_in[p].standby_exit) begin
        next_st[p].standby_fault = 1'b0;
      end
      // Hardware events are applied last so that they beat a clear.
      if (port_in[p].resume_fault || port_in[p].suspend_fault) begin
        next_st[p].fault = 1'b1; // see R13
      end
      if (port_in[p].standby_error) begin
        next_st[p].standby_fault = 1'b1; // see R15
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        st[p] <= PORT_ST_RST;
      end else begin
        st[p] <= next_st[p];
      end
    end

    // The port logic keeps a disabled port toning but never lets it go active.
    assign port_disable[p] = st[p].dis; // see R10
    assign scramble_off[p] = st[p].scramble_off;
    assign port_suspend[p] = st[p].fault; // see R13
    assign standby_err_clear[p] = st[p].standby_clear;
  end

  // ---------------------------------------------------------------------------
  // Read multiplexer
  // ---------------------------------------------------------------------------
  // Reads use the next values, except the connected bit, so that a read straight after a write sees it.
  always_comb begin
    cps_port_st_type sp;
    logic sp_con;
    logic sp_ok;
    sp = PORT_ST_RST;
    sp_con = 1'b0;
    sp_ok = 1'b0;
    next_hrdata = RDATA_ZERO;
    for (int i = 0; i < NPORTS; i++) begin
      if (next_port_sel == SEL_W'(i)) begin
        sp = next_st[i];
        sp_con = con[i];
        sp_ok = (next_page_sel == PAGE_PORT_STATUS); // see R19
      end
    end
    if (addr_take && !hwrite && addr_ok) begin
      if (addr_idx == IDX_SELECT) begin
        next_hrdata[POS_PAGE +: PAGE_W] = next_page_sel;
        next_hrdata[POS_PORT +: SEL_W] = next_port_sel;
      end else if (addr_idx == IDX_EVENT) begin
        next_hrdata[POS_PEI] = next_pei;
        next_hrdata[POS_TREE] = next_tree_valid;
      end else if (sp_ok && addr_idx == IDX_PORT_A) begin
        next_hrdata[POS_LINE_A +: LINE_W] = sp.line_a; // see R1
        next_hrdata[POS_LINE_B +: LINE_W] = sp.line_b; // see R2
        next_hrdata[POS_CHILD] = sp.child_role; // see R3
        next_hrdata[POS_CONN] = sp_con; // see R5
        next_hrdata[POS_RECEIVE_GOOD] = sp.receive_good;
        next_hrdata[POS_DIS] = sp.dis;
      end else if (sp_ok && addr_idx == IDX_PORT_B) begin
        next_hrdata[POS_SPEED +: SPEED_W] = sp.speed;
        next_hrdata[POS_PIE] = sp.port_event_irq_enable;
        next_hrdata[POS_FAULT] = sp.fault;
        next_hrdata[POS_SBF] = sp.standby_fault;
        next_hrdata[POS_DSCR] = sp.scramble_off;
        next_hrdata[POS_BONLY] = sp.beta_only;
      end else if (sp_ok && addr_idx == IDX_PORT_C) begin
        next_hrdata[POS_DCA] = sp.direct_current_attach;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  // Every port is watched, so the checks follow whichever port traffic reaches.
  for (genvar q = 0; q < NPORTS; q++) begin : g_chk
    logic rd_q;
    assign rd_q = addr_take && !hwrite && addr_ok && (port_sel == SEL_W'(q)) && !wr_en &&
        (page_sel == PAGE_PORT_STATUS);

    property p_line_a;
      @(posedge hclk) disable iff (!hresetn)
        rd_q && addr_idx == IDX_PORT_A |=>
        hrdata[POS_LINE_A +: LINE_W] == $past(port_in[q].tpa_state);
    endproperty
    a_line_a: assert property (p_line_a) // see R1
      else $error("TPA line state misreported");

    property p_line_b;
      @(posedge hclk) disable iff (!hresetn)
        rd_q && addr_idx == IDX_PORT_A |=>
        hrdata[POS_LINE_B +: LINE_W] == $past(port_in[q].tpb_state);
    endproperty
    a_line_b: assert property (p_line_b) // see R2
      else $error("TPB line state misreported");

    property p_child;
      @(posedge hclk) disable iff (!hresetn)
        (!con[q] || st[q].dis || st[q].fault) |=> st[q].child_role;
    endproperty
    a_child: assert property (p_child) // see R3
      else $error("inactive port not reported as child");

    property p_tones_only;
      @(posedge hclk) disable iff (!hresetn)
        port_in[q].beta_mode && port_in[q].tones_only |=> !st[q].receive_good;
    endproperty
    a_tones_only: assert property (p_tones_only) // see R8
      else $error("receive-good set on tones alone");

    property p_disable;
      @(posedge hclk) disable iff (!hresetn)
        wr_en && page_ok && port_sel == SEL_W'(q) && wr_idx == IDX_PORT_A |=>
        port_disable[q] == $past(hwdata[POS_DIS]);
    endproperty
    a_disable: assert property (p_disable) // see R9
      else $error("port disable did not follow the write");

    // Flag and notify load at the same edge; a clear may follow at once.
    property p_event;
      @(posedge hclk) disable iff (!hresetn)
        st[q].port_event_irq_enable && port_in[q].port_event |=> port_event_irq_flag && port_event_notify;
    endproperty
    a_event: assert property (p_event) // see R12
      else $error("enabled port event did not reach the link");

    property p_fault_set;
      @(posedge hclk) disable iff (!hresetn)
        port_in[q].resume_fault || port_in[q].suspend_fault |=> st[q].fault && port_suspend[q];
    endproperty
    a_fault_set: assert property (p_fault_set) // see R13
      else $error("fault did not set and suspend");

    property p_fault_clear;
      @(posedge hclk) disable iff (!hresetn)
        wr_en && page_ok && port_sel == SEL_W'(q) && wr_idx == IDX_PORT_B && hwdata[POS_FAULT] &&
        !port_in[q].resume_fault && !port_in[q].suspend_fault |=> !st[q].fault;
    endproperty
    a_fault_clear: assert property (p_fault_clear) // see R14
      else $error("write of one did not clear fault");

    property p_speed_ro;
      @(posedge hclk) disable iff (!hresetn)
        !port_in[q].speed_load |=> $stable(st[q].speed);
    endproperty
    a_speed_ro: assert property (p_speed_ro) // see R21
      else $error("agreed speed changed without a load");
  end

  property p_absent_port;
    @(posedge hclk) disable iff (!hresetn)
      addr_take && !hwrite && !wr_en && addr_idx >= IDX_PORT_A &&
      int'(port_sel) >= NPORTS |=> hrdata == RDATA_ZERO;
  endproperty
  a_absent_port: assert property (p_absent_port) // see R19
    else $error("absent port read as nonzero");

  c_fault: cover property (@(posedge hclk) disable iff (!hresetn) $rose(|port_suspend));
  c_event: cover property (@(posedge hclk) disable iff (!hresetn) $rose(port_event_notify));
  c_con: cover property (@(posedge hclk) disable iff (!hresetn) $rose(|con));
  c_read: cover property (@(posedge hclk) disable iff (!hresetn)
      addr_take && !hwrite ##1 hrdata != RDATA_ZERO);
endmodule

// ==== tb/cps_peer_model.sv ====
// Peer PHY model that drives the cable-side inputs of each port.
`timescale 1ns/1ns
module cps_peer_model (
  input wire logic hclk,
  output cps_pkg::cps_port_in_type port_in [3]
);
  import cps_pkg::*;
  initial for (int i = 0; i < 3; i++) port_in[i] = '0;
  task automatic legacy(input int p, input cps_line_type a, input cps_line_type b);
    @(posedge hclk);
    port_in[p].tpa_state <= a;
    port_in[p].tpb_state <= b;
    port_in[p].bias_ok <= 1'b1;
    port_in[p].dc_detect <= 1'b1;
  endtask
  // A coupled peer keeps tones and negotiation up, so the link stays connected.
  task automatic beta(input int p, input logic only);
    @(posedge hclk);
    port_in[p].beta_mode <= 1'b1;
    port_in[p].tones_seen <= 1'b1;
    port_in[p].speed_negotiated <= 1'b1;
    port_in[p].signal_valid <= 1'b1;
    port_in[p].tones_only <= only;
  endtask
  task automatic pulse(input int p, input int k);
    cps_port_in_type v;
    v = port_in[p];
    v.agreed_speed = SPEED_S800;
    v.speed_load = (k == 0);
    v.port_event = (k == 1);
    v.resume_fault = (k == 2);
    v.standby_error = (k == 3);
    @(posedge hclk);
    port_in[p] <= v;
    v.speed_load = 1'b0;
    v.port_event = 1'b0;
    v.resume_fault = 1'b0;
    v.standby_error = 1'b0;
    @(posedge hclk);
    port_in[p] <= v;
  endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the cable port status page over AHB-Lite.
`timescale 1ns/1ns
module testbench;
  import cps_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic bus_reset = 1'b0;
  logic tree_id_done = 1'b0;
  cps_port_in_type port_in [3];
  logic [2:0] dis_o;
  logic [2:0] scr_o;
  logic [2:0] sus_o;
  logic [2:0] sbc_o;
  logic notify;
  int num_errors = 0;
  int tests_run = 0;
  always #5 hclk = ~hclk;
  cps_peer_model peer_u (.hclk(hclk), .port_in(port_in));
  cps_port_page #(.NPORTS(3), .DEBOUNCE_CYCLES(8)) dut_u (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(SIZE_WORD),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .bus_reset(bus_reset), .tree_id_done(tree_id_done), .port_in(port_in),
    .port_disable(dis_o), .scramble_off(scr_o), .port_suspend(sus_o),
    .standby_err_clear(sbc_o), .port_event_notify(notify));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask
  task automatic xfer(input logic w, input logic [3:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {26'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, 32'(hresp));
  endtask
  task automatic wr(input logic [3:0] idx, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, idx, d, r);
  endtask
  task automatic rd(input string n, input logic [3:0] idx, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, idx, 32'h0, r);
    chk(n, e, r);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // The whole sequence needs well under 1000 cycles.
  initial begin
    #100000;
    num_errors++;
    end_of_test;
  end
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rd("port0 reset", IDX_PORT_A, 32'h08);
    rd("ctl reset", IDX_PORT_B, 32'h00);
    wr(IDX_SELECT, 32'h10);
    rd("select", IDX_SELECT, 32'h10);
    peer_u.legacy(1, LINE_Z, LINE_ONE);
    rd("debouncing", IDX_PORT_A, 32'hda);
    repeat (20) @(posedge hclk);
    rd("legacy", IDX_PORT_A, 32'hd6);
    rd("dc attach", IDX_PORT_C, 32'h80);
    peer_u.beta(1, 1'b1);
    rd("tones only", IDX_PORT_A, 32'hd4);
    peer_u.beta(1, 1'b0);
    rd("beta valid", IDX_PORT_A, 32'hd6);
    peer_u.pulse(1, 0);
    wr(IDX_PORT_B, 32'hff);
    rd("speed", IDX_PORT_B, 32'h72);
    chk("scramble", 32'h2, 32'(scr_o));
    peer_u.pulse(1, 1);
    @(posedge hclk);
    chk("notify", 32'h1, 32'(notify));
    rd("event", IDX_EVENT, 32'h01);
    wr(IDX_EVENT, 32'h01);
    rd("event clr", IDX_EVENT, 32'h00);
    chk("notify clr", 32'h0, 32'(notify));
    peer_u.pulse(1, 2);
    rd("fault", IDX_PORT_B, 32'h7a);
    chk("suspend", 32'h2, 32'(sus_o));
    rd("fault child", IDX_PORT_A, 32'hde);
    wr(IDX_PORT_B, 32'h1a);
    rd("fault clr", IDX_PORT_B, 32'h72);
    peer_u.pulse(1, 3);
    rd("standby", IDX_PORT_B, 32'h76);
    wr(IDX_PORT_B, 32'h16);
    @(posedge hclk);
    chk("standby pulse", 32'h2, 32'(sbc_o));
    rd("standby clr", IDX_PORT_B, 32'h72);
    wr(IDX_PORT_A, 32'hff);
    rd("disabled", IDX_PORT_A, 32'hdf);
    chk("disable", 32'h2, 32'(dis_o));
    @(posedge hclk);
    tree_id_done <= 1'b1;
    @(posedge hclk);
    tree_id_done <= 1'b0;
    rd("tree ok", IDX_EVENT, 32'h02);
    bus_reset <= 1'b1;
    @(posedge hclk);
    bus_reset <= 1'b0;
    rd("bus reset", IDX_PORT_A, 32'hdf);
    rd("tree bad", IDX_EVENT, 32'h00);
    rd("ctl kept", IDX_PORT_B, 32'h72);
    wr(IDX_SELECT, 32'h30);
    rd("absent", IDX_PORT_A, 32'h00);
    wr(IDX_SELECT, 32'h11);
    rd("page1", IDX_PORT_B, 32'h00);
    rd("unmapped", 4'hf, 32'h00);
    // A hardware reset in mid-run must clear the control bits that bus reset keeps.
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    chk("disable rst", 32'h0, 32'(dis_o));
    chk("scramble rst", 32'h0, 32'(scr_o));
    wr(IDX_SELECT, 32'h10);
    rd("hw reset a", IDX_PORT_A, 32'hda);
    rd("hw reset b", IDX_PORT_B, 32'h00);
    end_of_test;
  end
endmodule
